// ---- design/pdr_pkg.sv ----
// Package: opcodes, parameter doubleword and timing for power down logic
package pdr_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_PGM_RESUME = 8'h8A;
  localparam logic [7:0] OP_PGM_SUSPEND = 8'h85;
  localparam logic [7:0] OP_ERS_SUSPEND = 8'h75;
  localparam logic [7:0] OP_ERS_RESUME = 8'h7A;
  localparam logic [7:0] OP_DPD_ENTER = 8'hB9;
  localparam logic [7:0] OP_DPD_EXIT = 8'hAB;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  // ****************************************
  // Parameter doubleword fields
  // ****************************************
  localparam logic [0:0] DW14_DPD_SUPPORTED = 1'h0;
  localparam logic [1:0] DW14_DELAY_UNIT = 2'h1;
  localparam logic [4:0] DW14_DELAY_COUNT = 5'h1D;
  localparam logic [3:0] DW14_RSVD_HI = 4'hF;
  localparam logic [1:0] DW14_POLL_LEGACY = 2'h1;
  localparam logic [1:0] DW14_RSVD_LO = 2'h3;
  localparam logic [31:0] DW14_VALUE = 32'h5CD5BDF7;
  localparam int STATUS_BUSY_BIT = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int WAKE_DELAY_US = 30;
  localparam int WAKE_CYCLES = WAKE_DELAY_US * CLK_MHZ;
  localparam int SCK_HALF_DIV = 4;
  localparam int OP_WIDTH = 8;
endpackage : pdr_pkg

// ---- design/pdr_link_if.sv ----
// Interface: serial link between host controller and flash command end
`timescale 1ns/1ps
interface pdr_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sck, output cs_n, output mosi, input miso);
  modport dev (input sck, input cs_n, input mosi, output miso);
endinterface : pdr_link_if

// ---- design/pdr_dev.sv ----
// Flash end: decodes power down, suspend, resume and status commands
`timescale 1ns/1ps
// Functional notes
// - 8Ah resumes suspended page program
// - Dword14 top bit zero: deep power down
// - B9h enters deep power down
// - ABh wakes device from deep power down
// - Host waits 30us after wake
// - 05h status read, bit0 busy flag
// - Dword14 reads 5C_D5_BD_F7
// - 85h suspends page program
// - 75h suspends erase, 7Ah resumes erase
module pdr_dev (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  pdr_link_if.dev link, // Serial link
  input wire logic pgm_busy_i, // Program engine running
  input wire logic ers_busy_i, // Erase engine running
  input wire logic dw14_rd_i, // Sideband: load dword14 for readout
  output logic pgm_suspend_o, // Pulse: suspend program
  output logic pgm_resume_o, // Pulse: resume program
  output logic ers_suspend_o, // Pulse: suspend erase
  output logic ers_resume_o, // Pulse: resume erase
  output logic dpd_o, // Deep power down active
  output logic waking_o, // Wake delay running
  output logic [31:0] dw14_o // Parameter doubleword
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] sck_s_q, cs_s_q, mosi_s_q;
  logic sck_d1_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      sck_d1_q <= 1'h0;
    end else begin
      sck_s_q <= {sck_s_q[0], link.sck};
      cs_s_q <= {cs_s_q[0], link.cs_n};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire sck_rise = sck_s_q[1] & ~sck_d1_q;
  wire sck_fall = ~sck_s_q[1] & sck_d1_q;
  wire cs_act = ~cs_s_q[1];
  // ****************************************
  // Opcode shifter
  // ****************************************
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] out_q, out_d;
  logic miso_q;
  assign sh_d = {sh_q[6:0], mosi_s_q[1]};
  wire op_done = cs_act && sck_rise && (cnt_q == 4'h7);
  wire [7:0] op = sh_d;
  assign cnt_d = !cs_act ? 4'h0 :
                 (sck_rise && cnt_q != 4'h8) ? cnt_q + 4'h1 : cnt_q;
  // ****************************************
  // Power down state
  // ****************************************
  logic [10:0] wake_cnt_q;
  logic dpd_q, wake_q;
  wire busy = pgm_busy_i | ers_busy_i | wake_q;
  wire active = !dpd_q && !wake_q;
  wire dec_enter = op_done && active && op == pdr_pkg::OP_DPD_ENTER;
  wire dec_exit = op_done && dpd_q && op == pdr_pkg::OP_DPD_EXIT;
  wire dec_stat = op_done && !dpd_q && op == pdr_pkg::OP_READ_STATUS;
  wire [7:0] stat_byte = {7'h0, busy};
  assign out_d = dec_stat ? stat_byte :
                 (sck_fall && cs_act) ? {out_q[6:0], 1'b0} : out_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      out_q <= 8'h00;
      miso_q <= 1'h0;
    end else begin
      if (cs_act && sck_rise) sh_q <= sh_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      if (!cs_act) miso_q <= 1'h0;
      else if (dec_stat) miso_q <= stat_byte[7];
      else if (sck_fall) miso_q <= out_q[6];
    end
  end
  assign link.miso = miso_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dpd_q <= 1'h0;
      wake_q <= 1'h0;
      wake_cnt_q <= 11'h000;
    end else if (dec_enter) begin
      dpd_q <= 1'h1;
    end else if (dec_exit) begin
      dpd_q <= 1'h0;
      wake_q <= 1'h1;
      wake_cnt_q <= 11'(pdr_pkg::WAKE_CYCLES - 1);
    end else if (wake_q) begin
      if (wake_cnt_q == 11'h000) wake_q <= 1'h0;
      else wake_cnt_q <= wake_cnt_q - 11'h001;
    end
  end
  // ****************************************
  // Output registers: suspend and resume pulses, power state, dword14
  // ****************************************
  wire [31:0] dw14_w = {pdr_pkg::DW14_DPD_SUPPORTED,
    pdr_pkg::OP_DPD_ENTER, pdr_pkg::OP_DPD_EXIT,
    pdr_pkg::DW14_DELAY_UNIT, pdr_pkg::DW14_DELAY_COUNT,
    pdr_pkg::DW14_RSVD_HI, pdr_pkg::DW14_POLL_LEGACY,
    pdr_pkg::DW14_RSVD_LO};
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pgm_suspend_o <= 1'h0;
      pgm_resume_o <= 1'h0;
      ers_suspend_o <= 1'h0;
      ers_resume_o <= 1'h0;
      dpd_o <= 1'h0;
      waking_o <= 1'h0;
      dw14_o <= 32'h00000000;
    end else begin
      pgm_suspend_o <= op_done && active && op == pdr_pkg::OP_PGM_SUSPEND;
      pgm_resume_o <= op_done && active && op == pdr_pkg::OP_PGM_RESUME;
      ers_suspend_o <= op_done && active && op == pdr_pkg::OP_ERS_SUSPEND;
      ers_resume_o <= op_done && active && op == pdr_pkg::OP_ERS_RESUME;
      dpd_o <= dpd_q;
      waking_o <= wake_q;
      if (dw14_rd_i) dw14_o <= dw14_w;
    end
  end
endmodule : pdr_dev

// ---- design/pdr_host.sv ----
// Host end: sends one opcode, optionally reads one status byte back
`timescale 1ns/1ps
module pdr_host (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  pdr_link_if.host link, // Serial link
  input wire logic req_i, // Pulse: start command
  input wire logic [7:0] op_i, // Opcode to send
  output logic busy_o, // Command in progress
  output logic done_o, // Pulse: command finished
  output logic [7:0] rdata_o, // Status byte read back
  output logic wait_o // Wake delay hold-off running
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_SHIFT = 4'h2, ST_END = 4'h4, ST_WAIT = 4'h8
  } pdr_st_e;
  pdr_st_e st_q;
  logic [7:0] tx_q, rx_q, op_q;
  logic [4:0] bits_q;
  logic [2:0] div_q;
  logic sck_q, cs_n_q;
  logic [10:0] wcnt_q;
  logic [1:0] miso_s_q;
  wire tick = div_q == 3'(pdr_pkg::SCK_HALF_DIV - 1);
  wire rd = op_q == pdr_pkg::OP_READ_STATUS;
  wire [4:0] nbits = rd ? 5'h10 : 5'h08;
  wire is_wake = op_q == pdr_pkg::OP_DPD_EXIT;
  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = tx_q[7];
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_s_q <= 2'h0;
      div_q <= 3'h0;
    end else begin
      miso_s_q <= {miso_s_q[0], link.miso};
      div_q <= (tick || st_q != ST_SHIFT) ? 3'h0 : div_q + 3'h1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      op_q <= 8'h00;
      bits_q <= 5'h00;
      sck_q <= 1'h0;
      cs_n_q <= 1'h1;
      wcnt_q <= 11'h000;
      busy_o <= 1'h0;
      done_o <= 1'h0;
      rdata_o <= 8'h00;
      wait_o <= 1'h0;
    end else begin
      done_o <= 1'h0;
      unique case (st_q)
        ST_IDLE: if (req_i) begin
          op_q <= op_i;
          tx_q <= op_i;
          bits_q <= 5'h00;
          cs_n_q <= 1'h0;
          busy_o <= 1'h1;
          st_q <= ST_SHIFT;
        end
        ST_SHIFT: if (tick) begin
          sck_q <= ~sck_q;
          if (!sck_q) begin
            rx_q <= {rx_q[6:0], miso_s_q[1]};
            bits_q <= bits_q + 5'h01;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            if (bits_q == nbits) st_q <= ST_END;
          end
        end
        ST_END: begin
          cs_n_q <= 1'h1;
          if (rd) rdata_o <= rx_q;
          if (is_wake) begin
            wcnt_q <= 11'(pdr_pkg::WAKE_CYCLES - 1);
            wait_o <= 1'h1;
            st_q <= ST_WAIT;
          end else begin
            busy_o <= 1'h0;
            done_o <= 1'h1;
            st_q <= ST_IDLE;
          end
        end
        ST_WAIT: if (wcnt_q == 11'h000) begin
          wait_o <= 1'h0;
          busy_o <= 1'h0;
          done_o <= 1'h1;
          st_q <= ST_IDLE;
        end else begin
          wcnt_q <= wcnt_q - 11'h001;
        end
      endcase
    end
  end
endmodule : pdr_host

// ---- testbench/pdr_checker.sv ----
// Checker: framing of the serial link between host and flash ends
`timescale 1ns/1ps
module pdr_checker (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic sck, // Link clock
  input wire logic cs_n, // Select, active low
  input wire logic mosi, // Host to flash data
  input wire logic miso // Flash to host data
);
  logic sck_q;
  logic cs_n_q;
  logic [4:0] rise_q;
  logic [4:0] rise_d;
  // Link clock rises counted per frame
  assign rise_d = (cs_n_q && !cs_n) ? 5'h00 : rise_q + {4'h0, sck && !sck_q};
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      rise_q <= 5'h00;
    end else begin
      sck_q <= sck;
      cs_n_q <= cs_n;
      rise_q <= rise_d;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_hi4;
    sck [*4] ##1 !sck;
  endsequence
  sequence s_lo4;
    !sck [*4];
  endsequence
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  property p_sck_hi;
    $rose(sck) |-> s_hi4;
  endproperty
  property p_sck_lo;
    $fell(sck) |-> s_lo4;
  endproperty
  property p_mosi_hold;
    !cs_n && $changed(mosi) |-> !sck;
  endproperty
  property p_miso_hold;
    !cs_n && $changed(miso) |-> !sck;
  endproperty
  property p_frame_len;
    $rose(cs_n) |-> (rise_q == 5'h08) || (rise_q == 5'h10);
  endproperty
  property p_frame_start;
    $fell(cs_n) |-> !sck ##[1:8] $rose(sck);
  endproperty
  property p_frame_min;
    $fell(cs_n) |-> !cs_n [*8];
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("link clock active outside frame");
  a_sck_hi: assert property (p_sck_hi)
    else $error("link clock high phase wrong");
  a_sck_lo: assert property (p_sck_lo)
    else $error("link clock low phase wrong");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi changed while clock high");
  a_miso_hold: assert property (p_miso_hold)
    else $error("miso changed while clock high");
  a_frame_len: assert property (p_frame_len)
    else $error("frame bit count wrong");
  a_frame_start: assert property (p_frame_start)
    else $error("frame start timing wrong");
  a_frame_min: assert property (p_frame_min)
    else $error("frame too short");
endmodule : pdr_checker

// ---- testbench/pdr_tb_top.sv ----
// Testbench: host and flash ends joined, opcode and power state checks
`timescale 1ns/1ps
module pdr_tb_top;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_i = 1'b0;
  logic [7:0] op_i = 8'h00;
  logic pgm_busy_i = 1'b0;
  logic ers_busy_i = 1'b0;
  logic dw14_rd_i = 1'b0;
  logic busy_o, done_o, wait_o, dpd_o, waking_o;
  logic p0, p1, p2, p3;
  logic [7:0] rdata_o;
  logic [31:0] dw14_o;
  logic [31:0] rng = 32'h891B;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int last_n = 0;
  int pc [4] = '{0, 0, 0, 0};
  pdr_link_if link ();
  pdr_host i_pdr_host (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link),
    .req_i(req_i), .op_i(op_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .wait_o(wait_o));
  pdr_dev i_pdr_dev (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link),
    .pgm_busy_i(pgm_busy_i), .ers_busy_i(ers_busy_i), .dw14_rd_i(dw14_rd_i),
    .pgm_suspend_o(p0), .pgm_resume_o(p1), .ers_suspend_o(p2),
    .ers_resume_o(p3), .dpd_o(dpd_o), .waking_o(waking_o), .dw14_o(dw14_o));
  pdr_checker i_pdr_checker (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_sys_i) begin
    cyc++;
    pc[0] += (p0 === 1'b1);
    pc[1] += (p1 === 1'b1);
    pc[2] += (p2 === 1'b1);
    pc[3] += (p3 === 1'b1);
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task send(input logic [7:0] op);
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    op_i <= op;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    last_n = 0;
    while (done_o !== 1'b1 && last_n < 3000) begin
      @(negedge clk_sys_i);
      last_n++;
    end
    chk(last_n < 3000, "no done");
    chk(busy_o === 1'b0 && wait_o === 1'b0, "host still busy");
  endtask : send
  // Expect exc pulses on output idx and none elsewhere
  task try_op(input logic [7:0] op, input int idx, input int exc);
    int b;
    int t;
    b = pc[idx];
    t = pc[0] + pc[1] + pc[2] + pc[3];
    send(op);
    repeat (6) @(negedge clk_sys_i);
    chk(pc[idx] - b == exc, "pulse count");
    chk(pc[0] + pc[1] + pc[2] + pc[3] - t == exc, "stray pulse");
  endtask : try_op
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    dw14_rd_i <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(dw14_o === {1'b0, 8'hB9, 8'hAB, 2'b01, 5'b11101, 4'hF, 2'b01,
      2'b11}, "dword");
    chk(dw14_o === 32'h5CD5BDF7, "dword hex");
    chk(dw14_o[31] === 1'b0, "power down bit");
    chk(dw14_o[7:4] === 4'hF && dw14_o[1:0] === 2'b11, "reserved");
    try_op(8'h8A, 1, 1);
    try_op(8'h85, 0, 1);
    try_op(8'h75, 2, 1);
    try_op(8'h7A, 3, 1);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      @(posedge clk_sys_i);
      pgm_busy_i <= rng[0];
      ers_busy_i <= rng[1];
      send(8'h05);
      chk(rdata_o === {7'h00, rng[0] | rng[1]}, "status");
    end
    @(posedge clk_sys_i);
    pgm_busy_i <= 1'b0;
    ers_busy_i <= 1'b0;
    send(8'hB9);
    chk(dpd_o === 1'b1, "no power down");
    try_op(8'h85, 0, 0);
    send(8'h05);
    chk(rdata_o === 8'h00, "status in power down");
    send(8'hAB);
    chk(last_n >= 1500, "wake hold-off short");
    repeat (20) @(negedge clk_sys_i);
    chk(dpd_o === 1'b0 && waking_o === 1'b0, "not awake");
    try_op(8'h8A, 1, 1);
    finish_test();
  end
endmodule : pdr_tb_top
